// ---- hdl/vccr_top.v ----
// Virtual channel capability words with the channel arbiter they describe
`timescale 1ns/100ps
`default_nettype none
`include "vccr_defs.vh"

module vccr_top (
	// Clock and reset
	input wire SYS_CLK,
	input wire RST_B,
	input wire CLK_EN,
	// Configuration access
	input wire CFG_RD,
	input wire CFG_WR,
	input wire [`VCCR_ADDR_W-1:0] CFG_ADDR,
	input wire [31:0] CFG_WDATA,
	output reg [31:0] CFG_RDATA,
	output reg CFG_ACK,
	output reg CFG_HIT,
	// General control strap
	input wire STRICT_PRIO_EN,
	// Channel arbitration
	input wire VC0_REQ,
	input wire EXT_REQ,
	output wire VC0_GNT,
	output wire EXT_GNT,
	output reg ARB_TABLE_APPLY
);

	reg strict_r;
	reg [2:0] low_prio_count;
	reg [7:0] channel_arb_table_location;
	reg [7:0] channel_arb_scheme_mask;
	reg [31:0] cap_one;
	reg [31:0] cap_two;
	reg [31:0] rdata_nxt;
	reg hit_nxt;
	wire unused_wdata;

	// Write data has no destination here
	assign unused_wdata = ^CFG_WDATA;

	// Control bit is on the same clock, so one register is enough
	always @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			strict_r <= 1'b0;
		end else if (CLK_EN) begin
			strict_r <= STRICT_PRIO_EN;
		end
	end

	always @* begin
		if (strict_r) begin
			low_prio_count = `VCCR_LP_COUNT_STRICT;
		end else begin
			low_prio_count = `VCCR_LP_COUNT_NORMAL;
		end
		if (low_prio_count == 3'h0) begin
			channel_arb_table_location = `VCCR_TBL_LOC_NONE;
			channel_arb_scheme_mask = `VCCR_SCHEME_NONE;
		end else begin
			channel_arb_table_location = `VCCR_TBL_LOC_VAL;
			// Bit 0 fixed round-robin, bit 1 weighted 32 phases
			channel_arb_scheme_mask = `VCCR_SCHEME_VAL;
		end
		cap_one = `VCCR_CAP_RESET;
		cap_one[`VCCR_TBL_SIZE_MSB:`VCCR_TBL_SIZE_LSB] =
			`VCCR_TBL_SIZE_VAL;
		cap_one[`VCCR_REF_CLK_MSB:`VCCR_REF_CLK_LSB] =
			`VCCR_REF_CLK_VAL;
		cap_one[`VCCR_LP_COUNT_MSB:`VCCR_LP_COUNT_LSB] = low_prio_count;
		cap_one[`VCCR_EXT_TOTAL_MSB:`VCCR_EXT_TOTAL_LSB] =
			`VCCR_EXT_TOTAL_VAL;
		cap_two = `VCCR_CAP_RESET;
		cap_two[`VCCR_TBL_LOC_MSB:`VCCR_TBL_LOC_LSB] =
			channel_arb_table_location;
		cap_two[`VCCR_SCHEME_MSB:`VCCR_SCHEME_LSB] = channel_arb_scheme_mask;
	end

	always @* begin
		rdata_nxt = 32'h00000000;
		hit_nxt = 1'b0;
		case (CFG_ADDR)
			`VCCR_CAP_ONE_OFFSET: begin
				hit_nxt = 1'b1;
				rdata_nxt = cap_one;
			end
			`VCCR_CAP_TWO_OFFSET: begin
				hit_nxt = 1'b1;
				rdata_nxt = cap_two;
			end
			default: begin
				hit_nxt = 1'b0;
				rdata_nxt = 32'h00000000;
			end
		endcase
	end

	// Writes are acknowledged but change nothing
	always @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			CFG_RDATA <= 32'h00000000;
			CFG_ACK <= 1'b0;
			CFG_HIT <= 1'b0;
			ARB_TABLE_APPLY <= 1'b0;
		end else if (CLK_EN) begin
			CFG_ACK <= CFG_RD | CFG_WR;
			CFG_HIT <= (CFG_RD | CFG_WR) & hit_nxt;
			if (CFG_RD) begin
				CFG_RDATA <= rdata_nxt;
			end else begin
				CFG_RDATA <= 32'h00000000;
			end
			// Zero location leaves the table as a scratch pad
			ARB_TABLE_APPLY <= (channel_arb_table_location != 8'h00);
		end
	end

	vccr_arbiter u_arb (
		.clk(SYS_CLK),
		.rst_b(RST_B),
		.clk_en(CLK_EN),
		.strict_en(strict_r),
		.vc0_req(VC0_REQ),
		.ext_req(EXT_REQ),
		.vc0_gnt_r(VC0_GNT),
		.ext_gnt_r(EXT_GNT)
	);

endmodule // vccr_top

`default_nettype wire

// ---- hdl/vccr_defs.vh ----
// Constants for the virtual channel capability words
`ifndef VCCR_DEFS_VH
`define VCCR_DEFS_VH

`define VCCR_ADDR_W 12
`define VCCR_CAP_ONE_OFFSET 12'h154
`define VCCR_CAP_TWO_OFFSET 12'h158

`define VCCR_TBL_SIZE_MSB 11
`define VCCR_TBL_SIZE_LSB 10
`define VCCR_TBL_SIZE_VAL 2'h2
`define VCCR_REF_CLK_MSB 9
`define VCCR_REF_CLK_LSB 8
`define VCCR_REF_CLK_VAL 2'h0
`define VCCR_LP_COUNT_MSB 6
`define VCCR_LP_COUNT_LSB 4
`define VCCR_LP_COUNT_NORMAL 3'h1
`define VCCR_LP_COUNT_STRICT 3'h0
`define VCCR_EXT_TOTAL_MSB 2
`define VCCR_EXT_TOTAL_LSB 0
`define VCCR_EXT_TOTAL_VAL 3'h1

`define VCCR_TBL_LOC_MSB 31
`define VCCR_TBL_LOC_LSB 24
`define VCCR_TBL_LOC_VAL 8'h03
`define VCCR_TBL_LOC_NONE 8'h00
`define VCCR_SCHEME_MSB 7
`define VCCR_SCHEME_LSB 0
`define VCCR_SCHEME_VAL 8'h03
`define VCCR_SCHEME_NONE 8'h00

`define VCCR_CAP_RESET 32'h00000000

`endif

// ---- hdl/vccr_arbiter.v ----
// Channel arbiter between VC0 and the extended channel
`timescale 1ns/100ps
`default_nettype none

module vccr_arbiter (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	input wire clk_en,
	// Mode
	input wire strict_en,
	// Requests and grants
	input wire vc0_req,
	input wire ext_req,
	output reg vc0_gnt_r,
	output reg ext_gnt_r
);

	reg last_ext_r;
	reg vc0_gnt_nxt;
	reg ext_gnt_nxt;

	always @* begin
		vc0_gnt_nxt = 1'b0;
		ext_gnt_nxt = 1'b0;
		if (strict_en) begin
			// Extended channel always wins, VC0 may starve
			ext_gnt_nxt = ext_req;
			vc0_gnt_nxt = vc0_req & ~ext_req;
		end else if (vc0_req & ext_req) begin
			ext_gnt_nxt = ~last_ext_r;
			vc0_gnt_nxt = last_ext_r;
		end else begin
			ext_gnt_nxt = ext_req;
			vc0_gnt_nxt = vc0_req;
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			vc0_gnt_r <= 1'b0;
			ext_gnt_r <= 1'b0;
			last_ext_r <= 1'b0;
		end else if (clk_en) begin
			vc0_gnt_r <= vc0_gnt_nxt;
			ext_gnt_r <= ext_gnt_nxt;
			if (vc0_gnt_nxt | ext_gnt_nxt) begin
				last_ext_r <= ext_gnt_nxt;
			end
		end
	end

endmodule // vccr_arbiter

`default_nettype wire

// ---- tb/vccr_chk.sv ----
// Checker for the capability words and the arbiter
`timescale 1ns/100ps
`default_nettype none
module vccr_chk (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic CLK_EN,
	// Access and mode
	input wire logic CFG_RD,
	input wire logic [11:0] CFG_ADDR,
	input wire logic [31:0] CFG_RDATA,
	input wire logic STRICT_PRIO_EN,
	// Arbitration
	input wire logic EXT_REQ,
	input wire logic VC0_GNT,
	input wire logic EXT_GNT,
	input wire logic ARB_TABLE_APPLY
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);
	// Mode must be steady, since it passes a register first
	sequence rd_one;
		CLK_EN && CFG_RD && CFG_ADDR == 12'h154 && $stable(STRICT_PRIO_EN);
	endsequence
	sequence rd_two;
		CLK_EN && CFG_RD && CFG_ADDR == 12'h158 && $stable(STRICT_PRIO_EN);
	endsequence
	cap_high_a:
	assert property (rd_one |=> CFG_RDATA[31:7] == 25'h10)
		else $error("cap one high bits");
	cap_low_a:
	assert property (rd_one |=> CFG_RDATA[3:0] == 4'h1)
		else $error("cap one low bits");
	lp_count_a:
	assert property (rd_one |=> CFG_RDATA[6:4] == {2'h0, !$past(STRICT_PRIO_EN)})
		else $error("low priority count");
	tbl_loc_a:
	assert property (rd_two |=> CFG_RDATA[31:24] == {6'h0, {2{!$past(STRICT_PRIO_EN)}}})
		else $error("table location");
	cap_two_mid_a:
	assert property (rd_two |=> CFG_RDATA[23:8] == 16'h0)
		else $error("cap two middle bits");
	scheme_a:
	assert property (rd_two |=> CFG_RDATA[7:0] == {6'h0, {2{!$past(STRICT_PRIO_EN)}}})
		else $error("scheme byte");
	strict_win_a:
	assert property (CLK_EN && STRICT_PRIO_EN && $stable(STRICT_PRIO_EN) && EXT_REQ
		|=> EXT_GNT && !VC0_GNT) else $error("strict grant");
	table_live_a:
	assert property (CLK_EN && $stable(STRICT_PRIO_EN)
		|=> ARB_TABLE_APPLY != $past(STRICT_PRIO_EN)) else $error("table apply");
endmodule // vccr_chk
bind vccr_top vccr_chk vccr_chk_inst (.*);
`default_nettype wire

// ---- tb/vccr_tb.sv ----
// Self-checking bench for the capability words
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic clk = 0, rst_b = 0, rd = 0, wr = 0, strict = 0, vreq = 0, ereq = 0;
	logic en = 1;
	logic [11:0] addr = 0;
	logic [31:0] wdata = 0, rdata;
	wire ack, hit, vgnt, egnt, apply;
	int n_errors = 0, compares = 0, cyc = 0;
	vccr_top vccr_top_inst (.SYS_CLK(clk), .RST_B(rst_b), .CLK_EN(en),
		.CFG_RD(rd), .CFG_WR(wr), .CFG_ADDR(addr), .CFG_WDATA(wdata),
		.CFG_RDATA(rdata), .CFG_ACK(ack), .CFG_HIT(hit),
		.STRICT_PRIO_EN(strict), .VC0_REQ(vreq), .EXT_REQ(ereq),
		.VC0_GNT(vgnt), .EXT_GNT(egnt), .ARB_TABLE_APPLY(apply));
	always #12.5 clk = ~clk;
	task chk(input logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task print_verdict;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Request stays up so back-to-back accesses need no idle cycle
	task acc(input logic w, input logic [11:0] a, input logic [31:0] e,
		input logic h);
		rd = !w;
		wr = w;
		addr = a;
		wdata = 32'hffffffff;
		@(negedge clk);
		chk({ack, hit}, {1'b1, h});
		chk(rdata, e);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 400) begin
			n_errors++;
			print_verdict;
		end
	end
	initial begin
		repeat (10) @(negedge clk);
		rst_b = 1;
		@(negedge clk);
		acc(0, 12'h154, 32'h00000811, 1);
		acc(0, 12'h158, 32'h03000003, 1);
		acc(1, 12'h154, 0, 1);
		acc(1, 12'h158, 0, 1);
		acc(0, 12'h154, 32'h00000811, 1);
		acc(0, 12'h150, 0, 0);
		rd = 0;
		chk(apply, 1);
		// Both requesting with strict off alternates, extended first
		ereq = 1;
		vreq = 1;
		@(negedge clk);
		chk({vgnt, egnt}, 1);
		@(negedge clk);
		chk({vgnt, egnt}, 2);
		@(negedge clk);
		chk({vgnt, egnt}, 1);
		strict = 1;
		repeat (2) @(negedge clk);
		chk(apply, 0);
		repeat (4) begin
			chk({vgnt, egnt}, 1);
			@(negedge clk);
		end
		acc(0, 12'h154, 32'h00000801, 1);
		acc(0, 12'h158, 0, 1);
		rd = 0;
		@(negedge clk);
		chk(ack, 0);
		// Enable low must freeze the bus outputs
		en = 0;
		rd = 1;
		addr = 12'h154;
		@(negedge clk);
		chk({ack, hit}, 0);
		chk(rdata, 0);
		rd = 0;
		en = 1;
		@(negedge clk);
		print_verdict;
	end
endmodule // tb
`default_nettype wire
